// [dv/cps_port_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Stands in for the three port state machines that feed the register block
module cps_port_model (
    input wire logic aclk,
    output var cps_pkg::cps_port_in_type [cps_pkg::NPORT-1:0] port_in
);
    // All ports idle and disconnected at time zero
    initial port_in = '0;
    // Hold a level on one field; the caller sits just after an edge
    task automatic put(input int p, input int b, input logic v);
        port_in[p][b] <= v;
    endtask
    // One-cycle event; two edges pass so a second pulse never lands in the same step
    task automatic pulse(input int p, input int b);
        port_in[p][b] <= 1'b1;
        @(posedge aclk);
        port_in[p][b] <= 1'b0;
        @(posedge aclk);
    endtask
endmodule
`default_nettype wire

// [dv/cps_port_regs_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Watches the bus handshakes and port 0 status outputs
module cps_port_regs_checker #(
    parameter int DEBOUNCE_CYC = cps_pkg::DEBOUNCE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cps_pkg::cps_port_in_type [cps_pkg::NPORT-1:0] port_in,
    input wire cps_pkg::cps_port_out_type [cps_pkg::NPORT-1:0] port_out
);
    // Edges seen with the cable present; wide so the full debounce count fits
    logic [31:0] hi_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hi_r <= '0;
        end else begin
            hi_r <= port_in[0].cable_detect ? hi_r + 32'h1 : '0;
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    write_answer_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) |-> ##2 s_axi_bvalid)
        else $error("write answer not two cycles after handshake");
    read_answer_a: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
        else $error("read answer late");
    write_drop_a: assert property ((s_axi_bvalid && s_axi_bready) |=> !s_axi_bvalid)
        else $error("write answer held after handshake");
    read_drop_a: assert property ((s_axi_rvalid && s_axi_rready) |=> !s_axi_rvalid)
        else $error("read answer held after handshake");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while answer pending");
    write_busy_a: assert property (s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
        else $error("write accepted while answer pending");
    legacy_act_a: assert property ((port_out[0].connected && port_out[0].rx_signal_valid && !port_out[0].fast_mode) [*2]
        |-> port_out[0].legacy_active) else $error("legacy activity missing");
    debounce_a: assert property ($rose(port_out[0].connected) |-> hi_r >= DEBOUNCE_CYC - 1)
        else $error("connected before debounce time");
    conn_drop_a: assert property (!port_in[0].cable_detect |=> !port_out[0].connected)
        else $error("connected without cable");
    cover property (s_axi_bvalid && s_axi_bresp == cps_pkg::RESP_SLVERR);
    cover property ($rose(port_out[0].connected));
    cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind cps_port_regs cps_port_regs_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) cps_port_regs_checker_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port_in(port_in), .port_out(port_out)
);
`default_nettype wire

// [dv/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int DEB = 8; // Short debounce keeps the run brief
    localparam int CD = 8, SOK = 7, FL = 6, CN = 5, NF = 4, SF = 3, BS = 2, LH = 1, SB = 0; // Field bits
    localparam logic [1:0] OK = cps_pkg::RESP_OKAY;
    logic aclk = 1'b0, aresetn = 1'b0, bus_reset = 1'b0;
    logic [4:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, arready, bvalid, rvalid;
    logic bready = 1'b1, rready = 1'b1; // Always ready, so answers are taken at once
    logic [1:0] bresp, rresp;
    cps_pkg::cps_port_in_type [cps_pkg::NPORT-1:0] port_in;
    cps_pkg::cps_port_out_type [cps_pkg::NPORT-1:0] port_out;
    int fail_count = 0, n_tests = 0, seed = 19, n;
    cps_port_regs #(.DEBOUNCE_CYC(DEB)) cps_port_regs_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bus_reset(bus_reset), .port_in(port_in), .port_out(port_out)
    );
    cps_port_model cps_port_model_i (.aclk(aclk), .port_in(port_in));
    initial begin
        forever #50 aclk = ~aclk;
    end
    // Speed codes above the capability fold down to it
    function automatic logic [31:0] clamp(input int c);
        return (c > cps_pkg::SPEED_CAP) ? 32'(cps_pkg::SPEED_CAP) : 32'(c);
    endfunction
    // Counter saturates at its ceiling
    function automatic logic [31:0] sat(input int k);
        return (k > 255) ? 32'h000000FF : 32'(k);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Address and data offered together, each released once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw, w;
        aw = 0;
        w = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (awready === 1'b1 && !aw) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1 && !w) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Watchdog far beyond the thousand or so cycles the tests need
    initial begin
        #(100 * 20000);
        fail_count++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(cps_pkg::REG_STAT, 32'h0000000B, OK);
        rd(cps_pkg::REG_CTRL, 32'h00000003, OK);
        chk(32'(port_out[0].tone_en), 32'h1);
        for (int c = 0; c < 8; c++) begin
            wr(cps_pkg::REG_CTRL, 32'(c), OK);
            rd(cps_pkg::REG_CTRL, clamp(c), OK);
        end
        wr(5'h14, 32'h0, cps_pkg::RESP_SLVERR);
        rd(5'h14, 32'h0, cps_pkg::RESP_SLVERR);
        $display("speed and reset test done");
        wr(cps_pkg::REG_SEL, 32'h1, OK);
        wr(cps_pkg::REG_SEL, 32'h3, OK);
        rd(cps_pkg::REG_SEL, 32'h1, OK);
        cps_port_model_i.pulse(1, NF);
        rd(cps_pkg::REG_STAT, 32'h0000001B, OK);
        wr(cps_pkg::REG_STAT, 32'h0, OK);
        rd(cps_pkg::REG_STAT, 32'h0000001B, OK);
        wr(cps_pkg::REG_STAT, 32'h10, OK);
        rd(cps_pkg::REG_STAT, 32'h0000000B, OK);
        cps_port_model_i.pulse(1, SF);
        rd(cps_pkg::REG_STAT, 32'h0000001B, OK);
        n = ($random(seed) & 63) + 1;
        repeat (n) cps_port_model_i.pulse(1, BS);
        rd(cps_pkg::REG_ERR, sat(n), OK);
        rd(cps_pkg::REG_ERR, 32'h0, OK);
        repeat (300) cps_port_model_i.pulse(1, BS);
        rd(cps_pkg::REG_ERR, sat(300), OK);
        wr(cps_pkg::REG_SEL, 32'h0, OK);
        rd(cps_pkg::REG_STAT, 32'h0000000B, OK);
        $display("flag and counter test done");
        wr(cps_pkg::REG_SEL, 32'h2, OK);
        // Loop hold only means something on a present cable; read back before debounce completes
        cps_port_model_i.put(2, CD, 1'b1);
        cps_port_model_i.pulse(2, LH);
        rd(cps_pkg::REG_STAT, 32'h0000004B, OK);
        bus_reset <= 1'b1;
        @(posedge aclk);
        bus_reset <= 1'b0;
        @(posedge aclk);
        rd(cps_pkg::REG_STAT, 32'h0000000B, OK);
        cps_port_model_i.put(2, CD, 1'b0);
        cps_port_model_i.put(2, SB, 1'b1);
        repeat (2) @(posedge aclk);
        rd(cps_pkg::REG_STAT, 32'h0000008B, OK);
        cps_port_model_i.put(2, SB, 1'b0);
        $display("loop and standby test done");
        wr(cps_pkg::REG_SEL, 32'h0, OK);
        wr(cps_pkg::REG_CTRL, 32'h1, OK);
        cps_port_model_i.put(0, CD, 1'b1);
        @(posedge aclk);
        cps_port_model_i.put(0, SOK, 1'b1);
        repeat (DEB - 2) @(posedge aclk);
        chk(32'(port_out[0].connected), 32'h0);
        repeat (6) @(posedge aclk);
        chk(32'(port_out[0].connected), 32'h1);
        chk(32'(port_out[0].legacy_active), 32'h1);
        cps_port_model_i.put(0, FL, 1'b1);
        @(posedge aclk);
        cps_port_model_i.pulse(0, CN);
        wr(cps_pkg::REG_CTRL, 32'h2, OK);
        rd(cps_pkg::REG_TRAIN, 32'h1, OK);
        chk(32'(port_out[0].fast_mode), 32'h1);
        wr(cps_pkg::REG_CTRL, 32'h0A, OK);
        repeat (2) @(posedge aclk);
        chk(32'({port_out[0].tone_en, port_out[0].connected}), 32'h3);
        chk(32'(port_out[0].may_activate), 32'h0);
        wr(cps_pkg::REG_CTRL, 32'h1A, OK);
        repeat (2) @(posedge aclk);
        chk(32'(port_out[0].tone_en), 32'h0);
        chk(32'({port_out[0].connected, port_out[0].rx_signal_valid}), 32'h0);
        $display("connection test done");
        close_out();
    end
endmodule
`default_nettype wire

// [logic/cps_pkg.sv]
package cps_pkg;
    // Port count and per-port speed capability
    localparam int NPORT = 3;
    localparam int SEL_W = 2;
    localparam logic [2:0] SPEED_CAP = 3'h3;
    localparam logic [2:0] SPEED_RSV = 3'h6;

    // Connection debounce time and its cycle count
    localparam int CLK_KHZ = 10000;
    localparam int DEBOUNCE_MS = 341;
    localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
    localparam int DEB_W = 22;

    // Invalid-symbol counter ceiling
    localparam logic [7:0] ERR_MAX = 8'hFF;

    // Register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] REG_SEL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h04;
    localparam logic [ADDR_W-1:0] REG_STAT = 5'h08;
    localparam logic [ADDR_W-1:0] REG_ERR = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_TRAIN = 5'h10;

    // Control register fields
    localparam int CTRL_LIMIT = 0;
    localparam int CTRL_DIS = 3;
    localparam int CTRL_HARD = 4;

    // Status register fields
    localparam int STAT_CAP = 0;
    localparam int STAT_LPP = 3;
    localparam int STAT_UNREL = 4;
    localparam int STAT_FAST = 5;
    localparam int STAT_LOOP = 6;
    localparam int STAT_STBY = 7;
    localparam int STAT_CONN = 8;
    localparam int STAT_RXV = 9;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Events and levels from one port state machine
    typedef struct packed {
        logic cable_detect;
        logic signal_ok;
        logic fast_link;
        logic conn_new;
        logic neg_fail;
        logic sync_fail;
        logic bad_symbol;
        logic loop_hold;
        logic standby;
    } cps_port_in_type;

    // Status and control handed back to one port
    typedef struct packed {
        logic connected;
        logic rx_signal_valid;
        logic fast_mode;
        logic legacy_active;
        logic tone_en;
        logic may_activate;
        logic [2:0] train_speed;
    } cps_port_out_type;

    // Stored fields of one port
    typedef struct packed {
        logic [2:0] limit;
        logic dis;
        logic hard;
        logic unrel;
        logic loop;
        logic stby;
        logic [7:0] errs;
        logic [DEB_W-1:0] deb;
        logic conn;
        logic rxv;
        logic fast;
        logic [2:0] train;
    } cps_pst_type;
endpackage

// [logic/cps_port_regs.sv]
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Speed codes 000..101 ascending, 110/111 reserved
// - Over-capability speed write stores port maximum
// - Speed limit sampled only at new connection
// - Power reset loads maximum capable speed
// - Local plug flag always reads one
// - Capability field reports maximum capable speed
// - Negotiation or sync failure sets unreliable
// - Write one clears unreliable, zero ignored
// - Fast-mode flag set only in fast mode
// - Connected, receiving, not fast means legacy active
// - Invalid symbol counter increments, saturates 255
// - Reading error counter clears it
// - Loop hold sets loop blocked flag
// - Bus reset or disconnect clears loop flag
// - Standby flag mirrors standby power state
// - Hard disable acts only when disabled
// - Hard disabled forces connected, receive flags low
// - Hard disabled port stops sending tones
// - Disable blocks activation, cleared by hard reset
// - Connected set after 341 ms stable
module cps_port_regs #(
    parameter int DEBOUNCE_CYC = cps_pkg::DEBOUNCE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [cps_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cps_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic bus_reset,
    input wire cps_pkg::cps_port_in_type [cps_pkg::NPORT-1:0] port_in,
    output cps_pkg::cps_port_out_type [cps_pkg::NPORT-1:0] port_out
);

    // Debounce terminal value at counter width
    localparam logic [cps_pkg::DEB_W-1:0] DEB_LAST =
        cps_pkg::DEB_W'(DEBOUNCE_CYC - 1);

    // Whole module state in one record
    typedef struct packed {
        cps_pkg::cps_pst_type [cps_pkg::NPORT-1:0] p;
        cps_pkg::cps_port_out_type [cps_pkg::NPORT-1:0] po;
        logic [cps_pkg::SEL_W-1:0] sel;
        logic aw_ok;
        logic w_ok;
        logic [cps_pkg::ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awrdy;
        logic wrdy;
        logic bvalid;
        logic [1:0] bresp;
        logic arrdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } cps_state_type;

    cps_state_type s_r; // Registered state
    cps_state_type s_nxt; // Next state

    // Registered outputs straight from the state record
    assign s_axi_awready = s_r.awrdy;
    assign s_axi_wready = s_r.wrdy;
    assign s_axi_bvalid = s_r.bvalid;
    assign s_axi_bresp = s_r.bresp;
    assign s_axi_arready = s_r.arrdy;
    assign s_axi_rvalid = s_r.rvalid;
    assign s_axi_rdata = s_r.rdata;
    assign s_axi_rresp = s_r.rresp;
    assign port_out = s_r.po;

    // Next-state logic: bus first, port hardware after, so set wins
    always_comb begin
        logic [cps_pkg::SEL_W-1:0] sl;
        logic [2:0] wspd;
        logic off;
        logic disc;
        logic rd_err;
        sl = s_r.sel;
        wspd = '0;
        off = 1'b0;
        disc = 1'b0;
        rd_err = 1'b0;
        s_nxt = s_r;

        // Capture write address and data in either order
        if (s_axi_awvalid && s_r.awrdy) begin
            s_nxt.aw_ok = 1'b1;
            s_nxt.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_r.wrdy) begin
            s_nxt.w_ok = 1'b1;
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
        end

        // Response handshake retires the write
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // Perform the write once both halves are held
        if (s_r.aw_ok && s_r.w_ok && !s_r.bvalid) begin
            s_nxt.aw_ok = 1'b0;
            s_nxt.w_ok = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = cps_pkg::RESP_OKAY;
            wspd = s_r.wdata[cps_pkg::CTRL_LIMIT +: 3];
            unique case (s_r.awaddr)
                cps_pkg::REG_SEL: begin
                    // Out-of-range port numbers are ignored
                    if (s_r.wstrb[0] && (32'(s_r.wdata[cps_pkg::SEL_W-1:0]) < cps_pkg::NPORT)) begin
                        s_nxt.sel = s_r.wdata[cps_pkg::SEL_W-1:0];
                    end
                end
                cps_pkg::REG_CTRL: begin
                    if (s_r.wstrb[0]) begin
                        // Reserved and too-fast codes clamp to capability
                        if (wspd > cps_pkg::SPEED_CAP) begin
                            s_nxt.p[sl].limit = cps_pkg::SPEED_CAP;
                        end else begin
                            s_nxt.p[sl].limit = wspd;
                        end
                        s_nxt.p[sl].dis = s_r.wdata[cps_pkg::CTRL_DIS];
                        s_nxt.p[sl].hard = s_r.wdata[cps_pkg::CTRL_HARD];
                    end
                end
                cps_pkg::REG_STAT: begin
                    // Write one clears, zero leaves the flag alone
                    if (s_r.wstrb[0] && s_r.wdata[cps_pkg::STAT_UNREL]) begin
                        s_nxt.p[sl].unrel = 1'b0;
                    end
                end
                cps_pkg::REG_ERR: begin
                    // Counter is cleared by reading only
                end
                cps_pkg::REG_TRAIN: begin
                    // Read-only
                end
                default: begin
                    s_nxt.bresp = cps_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Read returns the next cycle
        if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_r.arrdy) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rdata = '0;
            unique case (s_axi_araddr)
                cps_pkg::REG_SEL: begin
                    s_nxt.rdata[cps_pkg::SEL_W-1:0] = s_r.sel;
                end
                cps_pkg::REG_CTRL: begin
                    s_nxt.rdata[cps_pkg::CTRL_LIMIT +: 3] = s_r.p[sl].limit;
                    s_nxt.rdata[cps_pkg::CTRL_DIS] = s_r.p[sl].dis;
                    s_nxt.rdata[cps_pkg::CTRL_HARD] = s_r.p[sl].hard;
                end
                cps_pkg::REG_STAT: begin
                    s_nxt.rdata[cps_pkg::STAT_CAP +: 3] = cps_pkg::SPEED_CAP;
                    s_nxt.rdata[cps_pkg::STAT_LPP] = 1'b1;
                    s_nxt.rdata[cps_pkg::STAT_UNREL] = s_r.p[sl].unrel;
                    s_nxt.rdata[cps_pkg::STAT_FAST] = s_r.p[sl].fast;
                    s_nxt.rdata[cps_pkg::STAT_LOOP] = s_r.p[sl].loop;
                    s_nxt.rdata[cps_pkg::STAT_STBY] = s_r.p[sl].stby;
                    s_nxt.rdata[cps_pkg::STAT_CONN] = s_r.p[sl].conn;
                    s_nxt.rdata[cps_pkg::STAT_RXV] = s_r.p[sl].rxv;
                end
                cps_pkg::REG_ERR: begin
                    s_nxt.rdata[7:0] = s_r.p[sl].errs;
                    s_nxt.p[sl].errs = '0;
                end
                cps_pkg::REG_TRAIN: begin
                    s_nxt.rdata[2:0] = s_r.p[sl].train;
                end
                default: begin
                    rd_err = 1'b1;
                end
            endcase
            s_nxt.rresp = rd_err ? cps_pkg::RESP_SLVERR : cps_pkg::RESP_OKAY;
        end

        // Per-port hardware updates
        for (int i = 0; i < cps_pkg::NPORT; i++) begin
            // Hard disable only bites while the port is disabled
            off = s_r.p[i].dis && s_r.p[i].hard;
            disc = !port_in[i].cable_detect;

            // Debounce: cable must stay present for the full time
            if (disc || off) begin
                s_nxt.p[i].deb = '0;
                s_nxt.p[i].conn = 1'b0;
            end else if (!s_r.p[i].conn) begin
                if (s_r.p[i].deb == DEB_LAST) begin
                    s_nxt.p[i].conn = 1'b1;
                end else begin
                    s_nxt.p[i].deb = s_r.p[i].deb + 1'b1;
                end
            end

            // Receive flag is forced low when hard disabled
            s_nxt.p[i].rxv = port_in[i].signal_ok && !off;

            // Fast mode only on a live connection
            s_nxt.p[i].fast = port_in[i].fast_link && s_nxt.p[i].conn;

            // Limit is latched only when a connection is formed
            if (port_in[i].conn_new && !off) begin
                s_nxt.p[i].train = s_r.p[i].limit;
            end

            // Failures set the flag after any software clear
            if (port_in[i].neg_fail || port_in[i].sync_fail) begin
                s_nxt.p[i].unrel = 1'b1;
            end

            // Saturating count, applied after a read clear
            if (port_in[i].bad_symbol && s_nxt.p[i].errs != cps_pkg::ERR_MAX) begin
                s_nxt.p[i].errs = s_nxt.p[i].errs + 1'b1;
            end

            // A new tree build restarts loop detection, so clear wins
            if (bus_reset || disc) begin
                s_nxt.p[i].loop = 1'b0;
            end else if (port_in[i].loop_hold) begin
                s_nxt.p[i].loop = 1'b1;
            end

            // Standby mirror
            s_nxt.p[i].stby = port_in[i].standby;

            // Status handed back to the port state machine
            s_nxt.po[i].connected = s_nxt.p[i].conn;
            s_nxt.po[i].rx_signal_valid = s_nxt.p[i].rxv;
            s_nxt.po[i].fast_mode = s_nxt.p[i].fast;
            s_nxt.po[i].legacy_active = s_nxt.p[i].conn && s_nxt.p[i].rxv && !s_nxt.p[i].fast;
            s_nxt.po[i].tone_en = !(s_nxt.p[i].dis && s_nxt.p[i].hard);
            s_nxt.po[i].may_activate = s_nxt.p[i].conn && !s_nxt.p[i].dis && !s_nxt.p[i].loop;
            s_nxt.po[i].train_speed = s_nxt.p[i].train;
        end

        // Ready flags: one write and one read in flight at a time
        s_nxt.awrdy = !s_nxt.aw_ok && !s_nxt.bvalid;
        s_nxt.wrdy = !s_nxt.w_ok && !s_nxt.bvalid;
        s_nxt.arrdy = !s_nxt.rvalid;
    end

    // State register with synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_r <= '0;
            // Ready once the bus is idle
            s_r.awrdy <= 1'b1;
            s_r.wrdy <= 1'b1;
            s_r.arrdy <= 1'b1;
            for (int i = 0; i < cps_pkg::NPORT; i++) begin
                // Enabled, maximum speed after power reset
                s_r.p[i].limit <= cps_pkg::SPEED_CAP;
                s_r.p[i].train <= cps_pkg::SPEED_CAP;
                s_r.p[i].dis <= 1'b0;
                s_r.po[i].tone_en <= 1'b1;
                s_r.po[i].train_speed <= cps_pkg::SPEED_CAP;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule

`default_nettype wire
